//--- rtl/msc_cap_regs.sv
`timescale 1ns/1ps
`include "msc_map.svh"
// Functional notes
// - message header low byte reads type 05h
// - header high byte is fixed next pointer
// - control bit 7 reports wide address ability
// - granted count bits 6:4 writable, reset zero
// - bits 3:1 report requested vector count
// - bit 0 picks messages over legacy pin
// - address bits 31:2 writable, 1:0 zero
// - data word goes on low data lanes
// - data at 8h narrow, Ch wide
// - upper address at 8h only when wide
// - storage capability spans two dwords
// - word0 type code 12h, top byte zero
// - word0 holds major and minor revision
// - word0 bits 15:8 fixed next pointer
// - word1 bits 23:4 give dword offset
// - io-space offset limited to 3FFFh
// - codes 4 to 9 select base registers
// - code Fh means pair follows word1
module msc_cap_regs #(
  parameter bit         WIDE_ADDR   = 1'b1,
  parameter logic [2:0] REQ_VECTORS = 3'h0,
  parameter logic [7:0] IRQ_NEXT    = `MSC_STORAGE_CAP_BASE,
  parameter logic [7:0] STOR_NEXT   = `MSC_NEXT_END,
  parameter logic [19:0] WIN_OFFSET = 20'h00000,
  parameter bit         WIN_IO      = 1'b0,
  parameter logic [3:0] WIN_SELECT  = `MSC_LOC_CONFIG
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire msc_pkg::msc_cfg_addr_t cfg_addr,
  input  wire logic                  cfg_rd,
  input  wire logic                  cfg_wr,
  input  wire logic [3:0]            cfg_be,
  input  wire msc_pkg::msc_dword_t   cfg_wdata,
  output msc_pkg::msc_dword_t        cfg_rdata,
  input  wire logic                  irq_event,
  input  wire logic                  msg_ready,
  output logic                       msg_valid,
  output logic                       msg_addr_phase,
  output msc_pkg::msc_dword_t        msg_ad,
  output logic                       legacy_irq_out,
  output logic                       message_irq_on,
  output logic [2:0]                 granted_vector_count
);
  import msc_pkg::*;

  // ---------------------------------------------------------------
  // constant fields
  // ---------------------------------------------------------------
  // an io-space window cannot reach past the 64 kB boundary,
  // so an oversized offset is clipped to the last dword
  localparam logic [19:0] WIN_OFS_LIM =
    (WIN_IO && WIN_OFFSET > `MSC_OFST_IO_MAX) ? `MSC_OFST_IO_MAX
                                              : WIN_OFFSET;
  // reserved location codes would mislead software,
  // so they are replaced by the config-space code
  localparam logic [3:0] WIN_SEL_OK =
    ((WIN_SELECT >= `MSC_LOC_BAR_FIRST &&
      WIN_SELECT <= `MSC_LOC_BAR_LAST) ||
     WIN_SELECT == `MSC_LOC_CONFIG) ? WIN_SELECT
                                    : `MSC_LOC_CONFIG;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  // config fields that software may change, then read return and sequencer state
  logic                  enable_ff,  nxt_enable;   // message mode
  logic [2:0]            granted_ff, nxt_granted;  // vector count
  logic [29:0]           addr_lo_ff, nxt_addr_lo;  // dword address
  logic [31:0]           addr_hi_ff, nxt_addr_hi;  // upper address
  logic [15:0]           data_ff,    nxt_data;     // message payload
  msc_dword_t            rdata_ff,   nxt_rdata;    // read return
  msc_state_e            state_ff,   nxt_state;    // write sequencer
  logic                  pend_ff,    nxt_pend;     // event waiting
  // message port and legacy pin outputs, all registered
  logic                  valid_ff,   nxt_valid;    // write in flight
  logic                  aphase_ff,  nxt_aphase;   // address phase
  msc_dword_t            ad_ff,      nxt_ad;       // address or data
  logic                  legacy_ff,  nxt_legacy;   // legacy pin level

  // byte-lane merge of a write into a dword
  // shared by every writable dword
  function automatic msc_dword_t merge(input msc_dword_t old_v,
                                       input msc_dword_t new_v,
                                       input logic [3:0] be);
    msc_dword_t res;
    // lanes whose enable is low keep their old byte
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // dword-aligned hit test relative to a capability base
  function automatic logic hit(input msc_cfg_addr_t a,
                               input msc_cfg_addr_t base,
                               input msc_cfg_addr_t ofs);
    msc_cfg_addr_t t;
    // sum wraps at 8 bits like the config address
    t = 8'(base + ofs);
    return a[7:2] == t[7:2];
  endfunction

  // ---------------------------------------------------------------
  // dword images of the capability registers
  // ---------------------------------------------------------------
  msc_dword_t img_irq0, img_addr, img_upper, img_data;
  msc_dword_t img_stor0, img_stor1;
  // read views; reserved bits are tied to zero here
  always_comb begin
    // header and control share one dword
    img_irq0  = {8'h00, WIDE_ADDR, granted_ff, REQ_VECTORS,
                 enable_ff, IRQ_NEXT,
                 `MSC_IRQ_CAP_TYPE};
    // low two address bits always read zero
    img_addr  = {addr_lo_ff, 2'h0};
    // upper half reads zero when wide mode is absent
    img_upper = WIDE_ADDR ? addr_hi_ff
                          : `MSC_RESET_ZERO32;
    // payload sits in the low half, top half zero
    img_data  = {16'h0000, data_ff};
    // storage capability: fixed words only
    img_stor0 = {8'h00, `MSC_REV_MAJOR, `MSC_REV_MINOR, STOR_NEXT,
                 `MSC_STORAGE_CAP_TYPE};
    img_stor1 = {8'h00, WIN_OFS_LIM, WIN_SEL_OK};
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic sel_irq0, sel_addr, sel_upper, sel_data, sel_stor0, sel_stor1;
  // one select per dword; at most one is high
  always_comb begin
    sel_irq0  = hit(cfg_addr, `MSC_IRQ_CAP_BASE, `MSC_OFS_HEADER);
    sel_addr  = hit(cfg_addr, `MSC_IRQ_CAP_BASE, `MSC_OFS_ADDRESS);
    // upper address only exists in wide mode
    sel_upper = WIDE_ADDR &&
                hit(cfg_addr, `MSC_IRQ_CAP_BASE, `MSC_OFS_UPPER);
    // data moves up one dword when wide
    sel_data  = WIDE_ADDR
      ? hit(cfg_addr, `MSC_IRQ_CAP_BASE, `MSC_OFS_DATA_WIDE)
      : hit(cfg_addr, `MSC_IRQ_CAP_BASE, `MSC_OFS_DATA_NARROW);
    // storage capability: base and base plus four
    sel_stor0 = hit(cfg_addr, `MSC_STORAGE_CAP_BASE,
                    `MSC_OFS_HEADER);
    sel_stor1 = hit(cfg_addr, `MSC_STORAGE_CAP_BASE,
                    `MSC_OFS_WORD1);
  end

  // ---------------------------------------------------------------
  // configuration write and read
  // ---------------------------------------------------------------
  // writes merge byte lanes into the current image
  always_comb begin
    msc_dword_t m;
    m           = `MSC_RESET_ZERO32;
    nxt_enable  = enable_ff;
    nxt_granted = granted_ff;
    nxt_addr_lo = addr_lo_ff;
    nxt_addr_hi = addr_hi_ff;
    nxt_data    = data_ff;
    nxt_rdata   = rdata_ff;
    // only writable fields take write data
    if (cfg_wr) begin
      if (sel_irq0) begin
        // only enable and granted count are live here
        m           = merge(img_irq0, cfg_wdata, cfg_be);
        nxt_enable  = m[16];
        nxt_granted = m[22:20];
      end
      if (sel_addr) begin
        // bits 1:0 of the write are dropped
        m           = merge(img_addr, cfg_wdata, cfg_be);
        nxt_addr_lo = m[31:2];
      end
      if (sel_upper) begin
        // full 32-bit register, plain byte merge
        nxt_addr_hi = merge(addr_hi_ff, cfg_wdata, cfg_be);
      end
      if (sel_data) begin
        // top half of the dword is reserved
        m        = merge(img_data, cfg_wdata, cfg_be);
        nxt_data = m[15:0];
      end
    end
    // read mux, unmapped dwords return zero
    // the last read value stands until the next read
    if (cfg_rd) begin
      unique case (1'b1)
        sel_irq0:  nxt_rdata = img_irq0;
        sel_addr:  nxt_rdata = img_addr;
        sel_upper: nxt_rdata = img_upper;
        sel_data:  nxt_rdata = img_data;
        sel_stor0: nxt_rdata = img_stor0;
        sel_stor1: nxt_rdata = img_stor1;
        default:   nxt_rdata = `MSC_RESET_ZERO32;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt delivery: message write or legacy pin
  // ---------------------------------------------------------------
  // events while messages are off go to the legacy pin
  // a busy sequencer keeps at most one event pending
  always_comb begin
    nxt_state  = state_ff;
    nxt_pend   = pend_ff | (irq_event & enable_ff);
    nxt_valid  = valid_ff;
    nxt_aphase = aphase_ff;
    nxt_ad     = ad_ff;
    // legacy level clears once messages take over
    nxt_legacy = ~enable_ff & (legacy_ff | irq_event);
    unique case (state_ff)
      MSC_IDLE: begin
        // launch the address phase of a pending message
        if (pend_ff && enable_ff) begin
          nxt_state  = MSC_ADDR;
          nxt_pend   = irq_event;
          nxt_valid  = 1'b1;
          nxt_aphase = 1'b1;
          nxt_ad     = {addr_lo_ff, 2'h0};
        end
      end
      MSC_ADDR: begin
        // hold the address until the host accepts it
        if (msg_ready) begin
          nxt_state  = MSC_DATA;
          nxt_aphase = 1'b0;
          nxt_ad     = {16'h0000, data_ff};
        end
      end
      MSC_DATA: begin
        // hold the data word until the host accepts it
        if (msg_ready) begin
          nxt_state = MSC_IDLE;
          nxt_valid = 1'b0;
          nxt_ad    = `MSC_RESET_ZERO32;
        end
      end
      default: begin
        // illegal code: drop back to idle
        nxt_state = MSC_IDLE;
        nxt_valid = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // single register bank; reset loads constants only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // everything clears while reset is low
      enable_ff  <= 1'b0;
      granted_ff <= 3'h0;
      addr_lo_ff <= 30'h0;
      addr_hi_ff <= `MSC_RESET_ZERO32;
      data_ff    <= `MSC_RESET_ZERO16;
      rdata_ff   <= `MSC_RESET_ZERO32;
      state_ff   <= MSC_IDLE;
      pend_ff    <= 1'b0;
      valid_ff   <= 1'b0;
      aphase_ff  <= 1'b0;
      ad_ff      <= `MSC_RESET_ZERO32;
      legacy_ff  <= 1'b0;
    end else begin
      // capture next values on every edge
      enable_ff  <= nxt_enable;
      granted_ff <= nxt_granted;
      addr_lo_ff <= nxt_addr_lo;
      addr_hi_ff <= nxt_addr_hi;
      data_ff    <= nxt_data;
      rdata_ff   <= nxt_rdata;
      state_ff   <= nxt_state;
      pend_ff    <= nxt_pend;
      valid_ff   <= nxt_valid;
      aphase_ff  <= nxt_aphase;
      ad_ff      <= nxt_ad;
      legacy_ff  <= nxt_legacy;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from flip-flops
  // ---------------------------------------------------------------
  // no logic between the registers and the pins
  assign cfg_rdata            = rdata_ff;
  assign msg_valid            = valid_ff;
  assign msg_addr_phase       = aphase_ff;
  assign msg_ad               = ad_ff;
  assign legacy_irq_out       = legacy_ff;
  assign message_irq_on       = enable_ff;
  assign granted_vector_count = granted_ff;
endmodule

//--- shared/msc_map.svh
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH
// ---------------------------------------------------------------
// capability placement in configuration space (byte addresses)
// ---------------------------------------------------------------
`define MSC_IRQ_CAP_BASE      8'h50
`define MSC_STORAGE_CAP_BASE  8'h70
// ---------------------------------------------------------------
// byte offsets inside the message and storage capabilities
// ---------------------------------------------------------------
`define MSC_OFS_HEADER        8'h00
`define MSC_OFS_CONTROL       8'h02
`define MSC_OFS_ADDRESS       8'h04
`define MSC_OFS_DATA_NARROW   8'h08
`define MSC_OFS_UPPER         8'h08
`define MSC_OFS_DATA_WIDE     8'h0C
`define MSC_OFS_WORD1         8'h04
// ---------------------------------------------------------------
// fixed codes and field values
// ---------------------------------------------------------------
`define MSC_IRQ_CAP_TYPE      8'h05
`define MSC_STORAGE_CAP_TYPE  8'h12
// structure revision values below are arbitrary
`define MSC_REV_MAJOR         4'h3
`define MSC_REV_MINOR         4'h2
`define MSC_NEXT_END          8'h00
`define MSC_OFST_IO_MAX       20'h03FFF
`define MSC_LOC_BAR_FIRST     4'h4
`define MSC_LOC_BAR_LAST      4'h9
`define MSC_LOC_CONFIG        4'hF
`define MSC_ADDR_LOW_MASK     32'hFFFFFFFC
`define MSC_RESET_ZERO32      32'h00000000
`define MSC_RESET_ZERO16      16'h0000
`endif

//--- shared/msc_pkg.sv
package msc_pkg;
  // message write sequencer states
  typedef enum logic [1:0] {
    MSC_IDLE = 2'b00,
    MSC_ADDR = 2'b01,
    MSC_DATA = 2'b10
  } msc_state_e;
  typedef logic [7:0]  msc_cfg_addr_t;
  typedef logic [31:0] msc_dword_t;
endpackage

//--- verification/msc_cap_properties.sv
`timescale 1ns/1ps
module msc_cap_checker #(
  parameter logic [2:0] REQ_VECTORS = 3'h0,
  parameter bit         WIDE_ADDR   = 1'b1
) (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire msc_pkg::msc_cfg_addr_t cfg_addr,
  input wire logic                  cfg_rd,
  input wire logic                  cfg_wr,
  input wire logic [3:0]            cfg_be,
  input wire msc_pkg::msc_dword_t   cfg_wdata,
  input wire msc_pkg::msc_dword_t   cfg_rdata,
  input wire logic                  irq_event,
  input wire logic                  msg_ready,
  input wire logic                  msg_valid,
  input wire logic                  msg_addr_phase,
  input wire msc_pkg::msc_dword_t   msg_ad,
  input wire logic                  legacy_irq_out,
  input wire logic                  message_irq_on,
  input wire logic [2:0]            granted_vector_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_header_type: assert property (
    cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata[7:0] == 8'h05)
    else $error("bad type code");
  a_next_pointer: assert property (
    cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata[15:8] == 8'h70)
    else $error("bad next pointer");
  a_control_fixed: assert property (
    cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata[31:23] == {8'h00, WIDE_ADDR})
    else $error("bad wide flag");
  a_request_count: assert property (
    cfg_rd && cfg_addr == 8'h50 |=> cfg_rdata[19:17] == REQ_VECTORS)
    else $error("bad request count");
  a_addr_aligned: assert property (
    cfg_rd && cfg_addr == 8'h54 |=> cfg_rdata[1:0] == 2'h0)
    else $error("address low bits set");
  a_storage_word0: assert property (
    cfg_rd && cfg_addr == 8'h70 |=> cfg_rdata == 32'h0032_0012)
    else $error("bad storage word0");
  a_storage_word1: assert property (
    cfg_rd && cfg_addr == 8'h74 |=> cfg_rdata[31:24] == 8'h00 &&
    cfg_rdata[3:0] inside {[4'h4:4'h9], 4'hF})
    else $error("bad storage word1");
  a_control_write: assert property (
    cfg_wr && cfg_addr == 8'h50 && cfg_be[2] |=>
    granted_vector_count == $past(cfg_wdata[22:20]) &&
    message_irq_on == $past(cfg_wdata[16]))
    else $error("control write lost");
  a_msg_launch: assert property (
    irq_event && message_irq_on && !msg_valid |->
    ##2 msg_valid && msg_addr_phase)
    else $error("message did not start");
  a_data_lanes: assert property (
    msg_valid && msg_addr_phase && msg_ready |=>
    msg_valid && !msg_addr_phase && msg_ad[31:16] == 16'h0000)
    else $error("bad data phase");
  a_phase_hold: assert property (
    msg_valid && !msg_ready |=>
    msg_valid && $stable(msg_ad) && $stable(msg_addr_phase))
    else $error("phase dropped early");
  a_legacy_pin: assert property (
    irq_event && !message_irq_on |-> ##[1:2] legacy_irq_out)
    else $error("legacy pin not set");
endmodule

//--- verification/msc_host_model.sv
`timescale 1ns/1ps
// host side: accepts each phase after a stall of some cycles
module msc_host_model (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic [3:0]          stall,
  input wire logic                msg_valid,
  input wire logic                msg_addr_phase,
  input wire msc_pkg::msc_dword_t msg_ad,
  output logic                    msg_ready,
  output msc_pkg::msc_dword_t     got_addr,
  output msc_pkg::msc_dword_t     got_data,
  output logic [7:0]              n_msg
);
  logic [3:0] wait_ff;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_ready <= 1'b0;
      wait_ff <= 4'h0;
      n_msg <= 8'h00;
    end else if (msg_valid && msg_ready) begin
      if (msg_addr_phase) got_addr <= msg_ad;
      else begin
        got_data <= msg_ad;
        n_msg <= n_msg + 8'h01;
      end
      msg_ready <= 1'b0;
      wait_ff <= 4'h0;
    end else if (msg_valid) begin
      wait_ff <= wait_ff + 4'h1;
      msg_ready <= (wait_ff >= stall);
    end
  end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import msc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic irq_event = 1'b0, msg_ready, msg_valid, msg_addr_phase;
  logic legacy_irq_out, message_irq_on;
  logic [2:0] granted_vector_count;
  logic [3:0] cfg_be = 4'h0, stall = 4'h0;
  logic [7:0] n_msg;
  msc_cfg_addr_t cfg_addr = 8'h00;
  msc_dword_t cfg_wdata = 32'h0, cfg_rdata, msg_ad, got_addr, got_data;
  msc_dword_t narrow_rdata;
  int n_fail = 0, checked = 0;
  always #20 clk = ~clk;
  msc_cap_regs #(.REQ_VECTORS(3'h3)) msc_cap_regs_inst (.clk, .rst_b,
    .cfg_addr, .cfg_rd, .cfg_wr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .irq_event, .msg_ready, .msg_valid, .msg_addr_phase, .msg_ad,
    .legacy_irq_out, .message_irq_on, .granted_vector_count);
  msc_host_model msc_host_model_inst (.clk, .rst_b, .stall, .msg_valid,
    .msg_addr_phase, .msg_ad, .msg_ready, .got_addr, .got_data, .n_msg);
  // second copy: narrow addressing, io window, reserved select code;
  // it shares the config bus and runs its messages in lockstep
  if (1) begin : narrow_cfg
    msc_cap_regs #(.WIDE_ADDR(1'b0), .REQ_VECTORS(3'h3),
      .WIN_OFFSET(20'hFFFFF), .WIN_IO(1'b1), .WIN_SELECT(4'h2))
      msc_cap_regs_inst (.clk, .rst_b, .cfg_addr, .cfg_rd, .cfg_wr,
      .cfg_be, .cfg_wdata, .cfg_rdata(narrow_rdata), .irq_event,
      .msg_ready, .msg_valid(), .msg_addr_phase(), .msg_ad(),
      .legacy_irq_out(), .message_irq_on(), .granted_vector_count());
  end
  task automatic check(input msc_dword_t seen, input msc_dword_t exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input msc_cfg_addr_t a, input msc_dword_t d,
                    input logic [3:0] be);
    @(posedge clk);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} <= {1'b1, a, d, be};
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input msc_cfg_addr_t a, input msc_dword_t exp);
    @(posedge clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 check(cfg_rdata, exp);
  endtask
  task automatic fire();
    @(posedge clk);
    irq_event <= 1'b1;
    @(posedge clk);
    irq_event <= 1'b0;
  endtask
  task automatic wait_msgs(input logic [7:0] want);
    for (int i = 0; i < 80 && n_msg != want; i++) begin
      @(posedge clk);
      #1;
    end
    if (n_msg !== want) begin
      n_fail++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h50, 32'h0086_7005);
    check(narrow_rdata, 32'h0006_7005);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h5C, 32'h0);
    rd(8'h70, 32'h0032_0012);
    rd(8'h74, 32'h0000_000F);
    check(narrow_rdata, 32'h0003_FFFF);
    rd(8'h60, 32'h0);
    wr(8'h50, 32'hFFB7_FFFF, 4'hF);
    rd(8'h50, 32'h00B7_7005);
    check({29'h0, granted_vector_count}, 32'h3);
    check({31'h0, message_irq_on}, 32'h1);
    wr(8'h50, 32'h0, 4'hB);
    rd(8'h50, 32'h00B7_7005);
    wr(8'h54, 32'hFFFF_FFFF, 4'hF);
    rd(8'h54, 32'hFFFF_FFFC);
    wr(8'h54, 32'h1234_5678, 4'hF);
    wr(8'h58, 32'hCAFE_0001, 4'hF);
    wr(8'h5C, 32'hFFFF_A5C3, 4'hF);
    rd(8'h58, 32'hCAFE_0001);
    check(narrow_rdata, 32'h0000_0001);
    rd(8'h5C, 32'h0000_A5C3);
    check(narrow_rdata, 32'h0);
    wr(8'h70, 32'hFFFF_FFFF, 4'hF);
    wr(8'h74, 32'hFFFF_FFFF, 4'hF);
    rd(8'h70, 32'h0032_0012);
    rd(8'h74, 32'h0000_000F);
    stall <= 4'h3;
    fire();
    repeat (3) @(posedge clk);
    fire();
    wait_msgs(8'h02);
    check(got_addr, 32'h1234_5678);
    check(got_data, 32'h0000_A5C3);
    stall <= 4'h0;
    fire();
    wait_msgs(8'h03);
    check({31'h0, legacy_irq_out}, 32'h0);
    wr(8'h50, 32'h0, 4'h4);
    rd(8'h50, 32'h0086_7005);
    fire();
    repeat (4) @(posedge clk);
    check({31'h0, legacy_irq_out}, 32'h1);
    check({24'h0, n_msg}, 32'h3);
    print_verdict();
  end
endmodule
bind msc_cap_regs msc_cap_checker #(.REQ_VECTORS(REQ_VECTORS),
  .WIDE_ADDR(WIDE_ADDR))
  msc_cap_checker_inst (.clk, .rst_b, .cfg_addr, .cfg_rd, .cfg_wr,
  .cfg_be, .cfg_wdata, .cfg_rdata, .irq_event, .msg_ready, .msg_valid,
  .msg_addr_phase, .msg_ad, .legacy_irq_out, .message_irq_on,
  .granted_vector_count);
